// >>> hw/charger_control_registers.sv
// Behaviour
// - Writing restore bit returns restorable fields to defaults and restarts watchdog.
// - Restore bit clears itself once the restore is done; reads return zero.
// - Writing kick bit restarts watchdog; the kick bit then clears itself.
// - Watchdog period code: 0 off, 1 is 40 s, 2 is 80 s, 3 is 160 s.
// - Auto drain enable applies battery discharge during battery overvoltage fault.
// - Forced battery drain applies discharge; cleared by restore or watchdog expiry.
// - Charge enable permits charging; returns to one on restore or expiry.
// - Input high-impedance bit cleared by restore, watchdog expiry, adapter plug-in.
// - Forced mid node drain sinks current; cleared by restore or expiry.
// - Thermal limit select picks 60 C at zero, 120 C at one.
// - Switching frequency codes 0,1,2 select frequency; code 3 reserved.
// - Gate drive codes 0 weak, 1 normal, 3 strong; code 2 reserved.
// - Input overvoltage select: 6.3 V at zero, 18.5 V at one.
// - Boost output enable turns boost on; cleared by restore or expiry.
// - Boost pulse-skip off bit stops pulse skipping in boost mode.
// - Buck pulse-skip off bit stops pulse skipping in buck mode.
// - Battery switch action other than normal waits 20 ms or 10 s per delay bit.
// - Battery switch action code selects normal, shutdown, ship or power reset.
// - Read-only bit shows whether switch-off is allowed with an adapter present.
`timescale 1ns/1ps
`default_nettype none
module charger_control_registers #(
	parameter logic [31:0] WD_CYCLES = 32'(charger_ctl_pkg::WD_BASE_CYCLES),
	parameter logic [31:0] SW_SHORT_CYCLES = 32'(charger_ctl_pkg::SWITCH_SHORT_CYCLES),
	parameter logic [31:0] SW_LONG_CYCLES = 32'(charger_ctl_pkg::SWITCH_LONG_CYCLES)
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic batOvpFault,
	input wire logic adapterPlugged,
	input wire logic switchWithInputOk,
	output logic batteryDrainOn,
	output logic midNodeDrainOn,
	output logic chargeEnable,
	output logic inputHighZ,
	output logic thermalLimitSel,
	output logic [1:0] switchFreqSel,
	output logic [1:0] gateDriveStrength,
	output logic inputOvervoltageSel,
	output logic boostOutputEn,
	output logic boostPulseSkipOff,
	output logic buckPulseSkipOff,
	output logic [1:0] batSwitchMode,
	output logic watchdogExpired
);
	import charger_ctl_pkg::*;

	logic [7:0] ctlA;
	logic [7:0] ctlB;
	logic [7:0] ctlC;
	logic restoreReq;
	logic kickReq;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] pinLevel;
	logic plugPrev;
	logic plugEvent;
	logic ovpLevel;
	logic wrA;
	logic wrB;
	logic wrC;
	logic wdExpire;
	logic [31:0] wdCount;
	logic switchPending;
	logic [31:0] switchCount;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Replaces the masked bits of a register with their default values.
	function automatic logic [7:0] toDefault(input logic [7:0] cur, input logic [7:0] def,
		input logic [7:0] mask);
		toDefault = (cur & ~mask) | (def & mask);
	endfunction : toDefault

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Three stages per pin; a level is accepted once stages two and three agree.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			sync3 <= 3'h0;
			pinLevel <= 3'h0;
			plugPrev <= 1'b0;
		end else begin
			sync1 <= {switchWithInputOk, adapterPlugged, batOvpFault};
			sync2 <= sync1;
			sync3 <= sync2;
			pinLevel <= (sync2 & sync3) | (pinLevel & (sync2 | sync3));
			plugPrev <= pinLevel[1];
		end
	end

	// Decoded writes and the adapter plug-in event.
	assign ovpLevel = pinLevel[0];
	assign plugEvent = pinLevel[1] && !plugPrev;
	assign wrA = regWrite && regAddr == ADDR_CTL_A;
	assign wrB = regWrite && regAddr == ADDR_CTL_B;
	assign wrC = regWrite && regAddr == ADDR_CTL_C;

	// ------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------
	// A kick or a restore restarts the timer one cycle after the write.
	watchdog_timer #(
		.BASE_CYCLES(WD_CYCLES)
	) wdog (
		.clk(clk),
		.rstn(rstn),
		.period(ctlA[WD_PERIOD_LO +: 2]),
		.restart(kickReq || restoreReq),
		.expire(wdExpire),
		.count(wdCount)
	);

	// ------------------------------------------------------------
	// Self-clearing command bits
	// ------------------------------------------------------------
	// Each is held for one cycle while it acts; a new write in that cycle sets it again.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			restoreReq <= 1'b0;
			kickReq <= 1'b0;
		end else begin
			restoreReq <= wrB && regWrData[REG_RESTORE];
			kickReq <= wrA && regWrData[TIMER_KICK] && !restoreReq;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Restore wins over a write; a write wins over expiry and plug-in clears.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctlA <= RESET_CTL_A;
		end else if (restoreReq) begin
			ctlA <= toDefault(ctlA, RESET_CTL_A, RESTORE_MASK_A);
		end else if (wrA) begin
			ctlA <= regWrData & ~(8'h1 << TIMER_KICK);
		end else begin
			ctlA <= wdExpire ? toDefault(ctlA, RESET_CTL_A, WDOG_MASK_A) : ctlA;
			if (wdExpire || plugEvent) begin
				ctlA[INPUT_HIGH_Z_EN] <= 1'b0;
			end
		end
	end

	// The restore bit itself is not kept here; reads take it from restoreReq.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctlB <= RESET_CTL_B & ~(8'h1 << REG_RESTORE);
		end else if (restoreReq) begin
			ctlB <= toDefault(ctlB, RESET_CTL_B, RESTORE_MASK_B) & ~(8'h1 << REG_RESTORE);
		end else if (wrB) begin
			ctlB <= regWrData & ~(8'h1 << REG_RESTORE);
		end
	end

	// The input-ok bit is read-only and comes from the pin.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctlC <= RESET_CTL_C;
		end else if (restoreReq) begin
			ctlC <= toDefault(ctlC, RESET_CTL_C, RESTORE_MASK_C);
		end else if (wrC) begin
			ctlC <= regWrData & ~(8'h1 << SWITCH_WITH_INPUT_OK);
		end else if (wdExpire) begin
			ctlC <= toDefault(ctlC, RESET_CTL_C, WDOG_MASK_C);
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Read data appear one cycle after the read strobe; other addresses read zero.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			regRdData <= READ_UNMAPPED;
		end else if (regRead) begin
			unique case (regAddr)
				ADDR_CTL_A: regRdData <= {ctlA[7:3], kickReq, ctlA[1:0]};
				ADDR_CTL_B: regRdData <= {restoreReq, ctlB[6:0]};
				ADDR_CTL_C: regRdData <= {ctlC[7:4], pinLevel[2], ctlC[2:0]};
				default: regRdData <= READ_UNMAPPED;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Battery switch action
	// ------------------------------------------------------------
	// A nonzero action waits the selected delay; normal takes effect at once.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			switchPending <= 1'b0;
			switchCount <= 32'h0;
			batSwitchMode <= ACTION_NORMAL;
		end else if (restoreReq || (wrC && regWrData[SWITCH_ACTION_LO +: 2] == ACTION_NORMAL)) begin
			switchPending <= 1'b0;
			switchCount <= 32'h0;
			batSwitchMode <= ACTION_NORMAL;
		end else if (wrC) begin
			switchPending <= 1'b1;
			switchCount <= regWrData[SWITCH_ACTION_DELAY] ? SW_LONG_CYCLES : SW_SHORT_CYCLES;
		end else if (switchPending) begin
			if (switchCount <= 32'h1) begin
				switchPending <= 1'b0;
				batSwitchMode <= ctlC[SWITCH_ACTION_LO +: 2];
			end else begin
				switchCount <= switchCount - 32'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	// Reserved frequency and drive codes leave the applied setting unchanged.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			batteryDrainOn <= 1'b0;
			midNodeDrainOn <= 1'b0;
			chargeEnable <= RESET_CTL_A[CHARGE_ENABLE_BIT];
			inputHighZ <= 1'b0;
			thermalLimitSel <= RESET_CTL_B[THERMAL_LIMIT_SEL];
			switchFreqSel <= RESET_CTL_B[SWITCH_FREQ_LO +: 2];
			gateDriveStrength <= RESET_CTL_B[GATE_DRIVE_LO +: 2];
			inputOvervoltageSel <= RESET_CTL_B[INPUT_OVERVOLTAGE_SEL];
			boostOutputEn <= 1'b0;
			boostPulseSkipOff <= 1'b0;
			buckPulseSkipOff <= 1'b0;
			watchdogExpired <= 1'b0;
		end else begin
			batteryDrainOn <= ctlA[FORCED_BATTERY_DRAIN] || (ctlA[AUTO_OVP_DRAIN_EN] && ovpLevel);
			midNodeDrainOn <= ctlA[FORCED_MID_NODE_DRAIN];
			chargeEnable <= ctlA[CHARGE_ENABLE_BIT];
			inputHighZ <= ctlA[INPUT_HIGH_Z_EN];
			thermalLimitSel <= ctlB[THERMAL_LIMIT_SEL];
			if (ctlB[SWITCH_FREQ_LO +: 2] != FREQ_RESERVED) begin
				switchFreqSel <= ctlB[SWITCH_FREQ_LO +: 2];
			end
			if (ctlB[GATE_DRIVE_LO +: 2] != DRIVE_RESERVED) begin
				gateDriveStrength <= ctlB[GATE_DRIVE_LO +: 2];
			end
			inputOvervoltageSel <= ctlB[INPUT_OVERVOLTAGE_SEL];
			boostOutputEn <= ctlC[BOOST_OUTPUT_EN];
			boostPulseSkipOff <= ctlC[BOOST_PULSE_SKIP_OFF];
			buckPulseSkipOff <= ctlC[BUCK_PULSE_SKIP_OFF];
			watchdogExpired <= wdExpire;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_restore_defaults: assert property (restoreReq |=> ctlA == RESET_CTL_A && ctlC[1:0] == 2'h0)
		else $error("restore did not return fields to defaults");
	a_restore_self_clear: assert property (restoreReq && !wrB |=>
		!restoreReq ##1 (!restoreReq || $past(wrB)))
		else $error("restore bit did not clear itself");
	a_kick_restart: assert property (kickReq |=> wdCount == 32'h0 && (!kickReq || $past(wrA)))
		else $error("kick did not restart timer or clear");
	a_wd_disabled: assert property (ctlA[1:0] == WD_OFF |=> !wdExpire)
		else $error("watchdog expired while disabled");
	a_auto_drain: assert property (ctlA[AUTO_OVP_DRAIN_EN] && ovpLevel |=> batteryDrainOn)
		else $error("no discharge during overvoltage fault");
	a_no_drain: assert property (!ctlA[7] && !ctlA[6] |=> !batteryDrainOn)
		else $error("discharge applied without cause");
	a_expiry_defaults: assert property (wdExpire && !regWrite && !restoreReq |=>
		ctlA[6:3] == 4'h4 && !ctlC[BOOST_OUTPUT_EN] ##1 !boostOutputEn && chargeEnable)
		else $error("watchdog expiry did not reset fields");
	a_plugin_high_z: assert property (plugEvent && !wrA |=> !ctlA[INPUT_HIGH_Z_EN] ##1 !inputHighZ)
		else $error("plug-in did not clear high-impedance bit");
	a_freq_reserved: assert property (ctlB[5:4] == FREQ_RESERVED |=> $stable(switchFreqSel))
		else $error("reserved frequency code applied");
	a_drive_reserved: assert property (ctlB[3:2] == DRIVE_RESERVED |=> $stable(gateDriveStrength))
		else $error("reserved drive code applied");
	a_switch_waits: assert property (wrC && regWrData[1:0] != ACTION_NORMAL && !restoreReq |=>
		$stable(batSwitchMode) ##1 ($stable(batSwitchMode) || $past(restoreReq) || $past(wrC)))
		else $error("switch action applied without delay");

	c_restore: cover property (restoreReq ##1 !restoreReq);
	c_kick: cover property (kickReq);
	c_expire: cover property (wdExpire);
	c_switch_done: cover property (switchPending ##1 !switchPending && batSwitchMode != ACTION_NORMAL);
endmodule : charger_control_registers
`default_nettype wire

// >>> hw/charger_ctl_pkg.sv
package charger_ctl_pkg;

	// ------------------------------------------------------------
	// Register addresses and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTL_A = 8'h16;
	localparam logic [7:0] ADDR_CTL_B = 8'h17;
	localparam logic [7:0] ADDR_CTL_C = 8'h18;
	localparam logic [7:0] RESET_CTL_A = 8'ha1;
	localparam logic [7:0] RESET_CTL_B = 8'h4f;
	localparam logic [7:0] RESET_CTL_C = 8'h04;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// Fields that a restore returns to default, and fields a watchdog expiry resets.
	localparam logic [7:0] RESTORE_MASK_A = 8'hff;
	localparam logic [7:0] RESTORE_MASK_B = 8'hfd;
	localparam logic [7:0] RESTORE_MASK_C = 8'h77;
	localparam logic [7:0] WDOG_MASK_A = 8'h78;
	localparam logic [7:0] WDOG_MASK_C = 8'h40;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int AUTO_OVP_DRAIN_EN = 7;
	localparam int FORCED_BATTERY_DRAIN = 6;
	localparam int CHARGE_ENABLE_BIT = 5;
	localparam int INPUT_HIGH_Z_EN = 4;
	localparam int FORCED_MID_NODE_DRAIN = 3;
	localparam int TIMER_KICK = 2;
	localparam int WD_PERIOD_LO = 0;
	localparam int REG_RESTORE = 7;
	localparam int THERMAL_LIMIT_SEL = 6;
	localparam int SWITCH_FREQ_LO = 4;
	localparam int GATE_DRIVE_LO = 2;
	localparam int INPUT_OVERVOLTAGE_SEL = 0;
	localparam int BOOST_OUTPUT_EN = 6;
	localparam int BOOST_PULSE_SKIP_OFF = 5;
	localparam int BUCK_PULSE_SKIP_OFF = 4;
	localparam int SWITCH_WITH_INPUT_OK = 3;
	localparam int SWITCH_ACTION_DELAY = 2;
	localparam int SWITCH_ACTION_LO = 0;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [1:0] WD_OFF = 2'h0;
	localparam logic [1:0] FREQ_RESERVED = 2'h3;
	localparam logic [1:0] DRIVE_RESERVED = 2'h2;
	localparam logic [1:0] ACTION_NORMAL = 2'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint CLK_HZ = 20000000;
	localparam longint WD_BASE_S = 40;
	localparam longint SWITCH_SHORT_MS = 20;
	localparam longint SWITCH_LONG_S = 10;
	localparam longint WD_BASE_CYCLES = WD_BASE_S * CLK_HZ;
	localparam longint SWITCH_SHORT_CYCLES = SWITCH_SHORT_MS * CLK_HZ / 1000;
	localparam longint SWITCH_LONG_CYCLES = SWITCH_LONG_S * CLK_HZ;

endpackage : charger_ctl_pkg

// >>> hw/watchdog_timer.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer #(
	parameter logic [31:0] BASE_CYCLES = 32'd800000000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [1:0] period,
	input wire logic restart,
	output logic expire,
	output logic [31:0] count
);
	import charger_ctl_pkg::*;

	logic [31:0] limit;

	// ------------------------------------------------------------
	// Timeout selection
	// ------------------------------------------------------------
	// Code 1 is the base period; each higher code doubles it.
	always_comb begin
		limit = BASE_CYCLES << (period - 2'h1);
	end

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// Counts while enabled, and restarts on a restart request or on expiry.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= 32'h0;
			expire <= 1'b0;
		end else if (restart || period == WD_OFF) begin
			count <= 32'h0;
			expire <= 1'b0;
		end else if (count >= limit - 32'h1) begin
			count <= 32'h0;
			expire <= 1'b1;
		end else begin
			count <= count + 32'h1;
			expire <= 1'b0;
		end
	end
endmodule : watchdog_timer
`default_nettype wire

// >>> tb/charger_control_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module charger_control_registers_tb;
	import charger_ctl_pkg::*;
	localparam int WD = 64;
	localparam int SWS = 8;
	localparam int SWL = 32;
	logic clk, rstn, regWrite, regRead, batOvpFault, adapterPlugged, switchWithInputOk;
	logic [7:0] regAddr, regWrData, regRdData;
	logic batteryDrainOn, midNodeDrainOn, chargeEnable, inputHighZ, thermalLimitSel;
	logic inputOvervoltageSel, boostOutputEn, boostPulseSkipOff, buckPulseSkipOff;
	logic watchdogExpired;
	logic [1:0] switchFreqSel, gateDriveStrength, batSwitchMode;
	int miscompares = 0;
	int compares = 0;

	charger_control_registers #(.WD_CYCLES(WD), .SW_SHORT_CYCLES(SWS), .SW_LONG_CYCLES(SWL))
	u_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.batOvpFault(batOvpFault), .adapterPlugged(adapterPlugged),
		.switchWithInputOk(switchWithInputOk), .batteryDrainOn(batteryDrainOn),
		.midNodeDrainOn(midNodeDrainOn), .chargeEnable(chargeEnable), .inputHighZ(inputHighZ),
		.thermalLimitSel(thermalLimitSel), .switchFreqSel(switchFreqSel),
		.gateDriveStrength(gateDriveStrength), .inputOvervoltageSel(inputOvervoltageSel),
		.boostOutputEn(boostOutputEn), .boostPulseSkipOff(boostPulseSkipOff),
		.buckPulseSkipOff(buckPulseSkipOff), .batSwitchMode(batSwitchMode),
		.watchdogExpired(watchdogExpired));

	host_model u_host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));

	// ------------------------------------------------------------
	// Clock, comparison and reporting helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Every value result is compared as a byte, with unknowns failing.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		u_host.rd(a, d);
		chk(d, exp, what);
	endtask : rdChk

	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Defaults after reset, an unmapped read, then the watchdog is switched off.
	task automatic t_reset();
		rdChk(ADDR_CTL_A, RESET_CTL_A, "reset a");
		rdChk(ADDR_CTL_B, RESET_CTL_B, "reset b");
		rdChk(ADDR_CTL_C, RESET_CTL_C, "reset c");
		rdChk(8'h20, READ_UNMAPPED, "unmapped");
		chk({chargeEnable, inputHighZ, thermalLimitSel, inputOvervoltageSel, switchFreqSel,
			gateDriveStrength}, 8'hb3, "reset outs");
		u_host.wr(ADDR_CTL_A, 8'ha0);
	endtask : t_reset

	// Drains, charge, high impedance, auto drain on fault and the plug-in clear.
	task automatic t_ctlA();
		u_host.wr(ADDR_CTL_A, 8'h58);
		cyc(3);
		chk({4'h0, batteryDrainOn, midNodeDrainOn, chargeEnable, inputHighZ}, 8'h0d, "a outs");
		rdChk(ADDR_CTL_A, 8'h58, "a back");
		u_host.wr(ADDR_CTL_A, 8'h80);
		batOvpFault <= 1'b1;
		cyc(8);
		chk({7'h0, batteryDrainOn}, 8'h01, "auto drain on");
		u_host.wr(ADDR_CTL_A, 8'h00);
		cyc(3);
		chk({7'h0, batteryDrainOn}, 8'h00, "auto drain off");
		batOvpFault <= 1'b0;
		u_host.wr(ADDR_CTL_A, 8'h10);
		cyc(3);
		chk({7'h0, inputHighZ}, 8'h01, "high z set");
		adapterPlugged <= 1'b1;
		cyc(8);
		rdChk(ADDR_CTL_A, 8'h00, "plug clear");
		chk({7'h0, inputHighZ}, 8'h00, "plug out");
	endtask : t_ctlA

	// Every frequency and drive code, then reserved codes that must not apply.
	task automatic t_ctlB();
		logic [1:0] drv;
		for (int i = 0; i < 3; i++) begin
			drv = (i == 2) ? 2'h3 : 2'(i);
			u_host.wr(ADDR_CTL_B, {2'b00, 2'(i), drv, 2'b11});
			cyc(3);
			chk({thermalLimitSel, inputOvervoltageSel, switchFreqSel, gateDriveStrength, 2'b00},
				{2'b01, 2'(i), drv, 2'b00}, "b codes");
		end
		u_host.wr(ADDR_CTL_B, 8'h38);
		cyc(3);
		chk({thermalLimitSel, inputOvervoltageSel, switchFreqSel, gateDriveStrength, 2'b00},
			8'h2c, "reserved codes");
		rdChk(ADDR_CTL_B, 8'h38, "b back");
	endtask : t_ctlB

	// Boost and pulse-skip bits, and the read-only pin bit that writes cannot touch.
	task automatic t_ctlC();
		u_host.wr(ADDR_CTL_C, 8'h70);
		cyc(3);
		chk({5'h0, boostOutputEn, boostPulseSkipOff, buckPulseSkipOff}, 8'h07, "c outs");
		switchWithInputOk <= 1'b1;
		u_host.wr(ADDR_CTL_C, 8'h00);
		cyc(5);
		rdChk(ADDR_CTL_C, 8'h08, "pin high");
		switchWithInputOk <= 1'b0;
		u_host.wr(ADDR_CTL_C, 8'h08);
		cyc(5);
		rdChk(ADDR_CTL_C, 8'h00, "pin low");
	endtask : t_ctlC

	// Each switch action with the short delay, a cancel, then the long delay.
	task automatic t_switch();
		for (int c = 1; c < 4; c++) begin
			u_host.wr(ADDR_CTL_C, 8'(c));
			cyc(SWS / 2);
			chk({6'h0, batSwitchMode}, 8'h00, "early mode");
			cyc(SWS);
			chk({6'h0, batSwitchMode}, 8'(c), "mode");
			u_host.wr(ADDR_CTL_C, 8'h00);
			cyc(2);
			chk({6'h0, batSwitchMode}, 8'h00, "cancel");
		end
		u_host.wr(ADDR_CTL_C, 8'h05);
		cyc(SWS + 4);
		chk({6'h0, batSwitchMode}, 8'h00, "long early");
		cyc(SWL);
		chk({6'h0, batSwitchMode}, 8'h01, "long mode");
	endtask : t_switch

	// A restore brings every restorable field back and clears itself.
	// The reserved bit of the second byte keeps the zero that the restoring write put there.
	task automatic t_restore();
		u_host.wr(ADDR_CTL_A, 8'h58);
		u_host.wr(ADDR_CTL_B, 8'h3a);
		u_host.wr(ADDR_CTL_B, 8'h80);
		cyc(3);
		rdChk(ADDR_CTL_A, 8'ha1, "restore a");
		rdChk(ADDR_CTL_B, 8'h4d, "restore b");
		rdChk(ADDR_CTL_C, 8'h04, "restore c");
		chk({chargeEnable, inputHighZ, thermalLimitSel, inputOvervoltageSel, switchFreqSel,
			gateDriveStrength}, 8'hb3, "restore outs");
	endtask : t_restore

	// Each period is timed from a kick; expiry resets only its own fields.
	task automatic t_wdog();
		int n;
		for (int p = 1; p < 4; p++) begin
			u_host.wr(ADDR_CTL_C, 8'h60);
			u_host.kick(8'hd8 | 8'(p));
			n = 0;
			while (watchdogExpired !== 1'b1 && n < 800) begin
				cyc(1);
				n++;
			end
			chk({7'h0, n >= (WD << (p - 1)) - 4 && n <= (WD << (p - 1)) + 4}, 8'h01,
				"period");
			cyc(3);
			rdChk(ADDR_CTL_A, 8'ha0 | 8'(p), "expiry a");
			rdChk(ADDR_CTL_C, 8'h20, "expiry c");
			chk({3'h0, batteryDrainOn, midNodeDrainOn, chargeEnable, inputHighZ, boostOutputEn},
				8'h04, "expiry outs");
		end
		u_host.wr(ADDR_CTL_A, 8'ha0);
		n = 0;
		while (watchdogExpired !== 1'b1 && n < 600) begin
			cyc(1);
			n++;
		end
		chk({7'h0, n == 600}, 8'h01, "disabled");
	endtask : t_wdog

	// ------------------------------------------------------------
	// Main sequence and hang guard
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		batOvpFault = 1'b0;
		adapterPlugged = 1'b0;
		switchWithInputOk = 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		cyc(1);
		t_reset();
		t_ctlA();
		t_ctlB();
		t_ctlC();
		t_switch();
		t_restore();
		t_wdog();
		close_out();
	end

	// The whole run needs about 1300 cycles; this cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("FAIL %0t run did not finish", $time);
		close_out();
	end
endmodule : charger_control_registers_tb
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host side of the register strobe port
// ------------------------------------------------------------
module host_model (
	input wire logic clk,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrite,
	output logic regRead,
	input wire logic [7:0] regRdData
);
	// The bus starts idle with unmapped junk on the address lines.
	initial begin
		regAddr = 8'hff;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
	end

	// One-cycle write strobe; released lines are scrambled so stale values never match.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
	endtask : wr

	// One-cycle read strobe; the data is taken once the strobe edge has settled.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		regAddr <= ~a;
		#1;
		d = regRdData;
	endtask : rd

	// A kick rewrites the first control byte with the kick bit set.
	task automatic kick(input logic [7:0] ctlA);
		wr(8'h16, ctlA | 8'h04);
	endtask : kick
endmodule : host_model
`default_nettype wire
